// ===== core/tsg_pkg.sv
// Shared constants and types of the test-signal mode generator core
package tsg_pkg;
	// Clock figures
	localparam int SYS_CLK_HZ      = 50_000_000;  // System clock rate
	localparam int MCLK_NOM_HZ     = 4_096_000;   // Nominal master clock rate
	localparam int SAMPLE_DIV      = 16;          // Master ticks per sample
	localparam int PHASE_STEPS     = 1024;        // Sine samples per period at top rate
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;    // Mode, range, octave, power down
	localparam logic [7:0] OFS_RATIO  = 8'h04;    // Ratio top and bottom
	localparam logic [7:0] OFS_ATTEN  = 8'h08;    // Digital attenuation
	localparam logic [7:0] OFS_LEVEL  = 8'h0C;    // Dc level word
	localparam logic [7:0] OFS_PULSE  = 8'h10;    // Pulse levels A and B
	localparam logic [7:0] OFS_STATUS = 8'h14;    // Read-only state
	// Field positions in the control register
	localparam int CTRL_MODE_LSB  = 0;            // Mode field [1:0]
	localparam int CTRL_RANGE_LSB = 2;            // Range field [4:2]
	localparam int CTRL_OCT_BIT   = 5;            // Octave divider bit
	localparam int CTRL_PD_BIT    = 6;            // Power down bit
	localparam int RATIO_BOT_LSB  = 8;            // Ratio bottom [15:8]
	localparam int PULSE_B_LSB    = 8;            // Pulse level B [12:8]
	localparam int STAT_MUTE_BIT  = 2;            // Mute flag in status
	localparam int STAT_PHASE_LSB = 16;           // Phase index [25:16]
	// Reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;  // Sine, 0 dB, running
	localparam logic [31:0] RATIO_RST = 32'h0000_0000;  // 250 Hz
	localparam logic [7:0]  ATTEN_RST = 8'h00;          // 0 dB
	localparam logic [23:0] LEVEL_RST = 24'h00_0000;    // Zero volts
	localparam logic [4:0]  PULSE_RST = 5'h00;          // Zero volts
	// Attenuation figures
	localparam logic [7:0] ATTEN_PER_6DB = 8'h0C;       // Half-dB steps per 6 dB
	localparam logic [3:0] MUTE_NIBBLE   = 4'hF;        // Upper nibble that mutes
	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;          // Normal answer
	localparam logic [1:0] RESP_SLVERR = 2'h2;          // Unmapped address
	// Operating modes
	typedef enum logic [1:0] {
		MODE_SINE  = 2'b00,
		MODE_DC    = 2'b01,
		MODE_DATA  = 2'b10,
		MODE_PULSE = 2'b11
	} tsg_mode_t;
endpackage

// ===== core/tsg_core.sv
// Test-signal mode generator core with an AXI4-Lite register port
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module tsg_core
#(
	parameter int MCLK_HZ = tsg_pkg::MCLK_NOM_HZ  // Master clock rate
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        phase_align_pin,
	input  wire logic        switch_or_bitstream_pin,
	output logic             mod_bit,
	output logic [2:0]       range_code,
	output logic             pulse_neg,
	output logic [3:0]       pulse_mag,
	output logic             pulse_sel,
	output logic             out_oe
);
	import tsg_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Functions
	// Byte-lane merge of a write
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction
	// Parabolic sine of a 10-bit phase, zero at phase 0
	function automatic logic signed [23:0] sine_of(input logic [9:0] ph);
		logic [17:0] p;
		logic [23:0] y;
		p = 18'({9'h000, ph[8:0]} * (18'h00200 - {9'h000, ph[8:0]}));
		y = 24'({p, 7'h00} - {7'h00, p});
		return ph[9] ? -$signed(y) : $signed(y);
	endfunction
	// Gain mantissa of the residual half-dB steps within 6 dB
	function automatic logic [15:0] mant_of(input logic [3:0] r);
		case (r)
			4'h0: return 16'hFFFF;
			4'h1: return 16'hF1AD;
			4'h2: return 16'hE428;
			4'h3: return 16'hD765;
			4'h4: return 16'hCB59;
			4'h5: return 16'hBFF8;
			4'h6: return 16'hB53B;
			4'h7: return 16'hAB18;
			4'h8: return 16'hA186;
			4'h9: return 16'h987D;
			4'hA: return 16'h8FF5;
			default: return 16'h87E7;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0]        ctrl_r;          // Control register
	logic [3:0]         ratio_top_r;     // Ratio numerator
	logic [7:0]         ratio_bot_r;     // Ratio denominator
	logic [7:0]         wave_digital_atten_r;
	logic [23:0]        level_word_r;    // Dc level
	logic [4:0]         pulse_level_a_r; // Pulse level while pin low
	logic [4:0]         pulse_level_b_r; // Pulse level while pin high
	logic [7:0]         wr_addr;         // Decoded write address
	logic               wr_fire;         // Write handshake edge
	logic               rd_fire;         // Read handshake edge
	logic               ratio_wr;        // Ratio register written

	// Field views of the control register
	wire tsg_mode_t mode_fld = tsg_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
	wire [2:0]      range_fld = ctrl_r[CTRL_RANGE_LSB +: 3];
	wire            octave_divider_bit = ctrl_r[CTRL_OCT_BIT];
	wire            pd_bit = ctrl_r[CTRL_PD_BIT];
	assign wr_addr  = s_axi_awaddr;
	assign wr_fire  = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
	assign rd_fire  = s_axi_arvalid & s_axi_arready;
	assign ratio_wr = wr_fire & (wr_addr == OFS_RATIO);

	// Write handshake: both channels taken together, then a response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b1;
			s_axi_bresp   <= (wr_addr <= OFS_PULSE && wr_addr[1:0] == 2'b00) ?
				RESP_OKAY : RESP_SLVERR;
		end else begin
			// Open both readies once address and data are both offered
			s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
			if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r               <= CTRL_RST;
			{ratio_bot_r, ratio_top_r} <= {RATIO_RST[15:8], RATIO_RST[3:0]};
			wave_digital_atten_r <= ATTEN_RST;
			level_word_r         <= LEVEL_RST;
			pulse_level_a_r      <= PULSE_RST;
			pulse_level_b_r      <= PULSE_RST;
		end else if (wr_fire) begin
			case (wr_addr)
				OFS_CTRL: ctrl_r <= wmerge(ctrl_r, s_axi_wdata, s_axi_wstrb) & 32'h0000_007F;
				OFS_RATIO: begin
					ratio_top_r <= s_axi_wstrb[0] ? s_axi_wdata[3:0] : ratio_top_r;
					ratio_bot_r <= s_axi_wstrb[1] ? s_axi_wdata[RATIO_BOT_LSB +: 8] : ratio_bot_r;
				end
				OFS_ATTEN: wave_digital_atten_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] :
					wave_digital_atten_r;
				OFS_LEVEL: level_word_r <= 24'(wmerge({8'h00, level_word_r}, s_axi_wdata,
					s_axi_wstrb));
				OFS_PULSE: begin
					pulse_level_a_r <= s_axi_wstrb[0] ? s_axi_wdata[4:0] : pulse_level_a_r;
					pulse_level_b_r <= s_axi_wstrb[1] ? s_axi_wdata[PULSE_B_LSB +: 5] :
						pulse_level_b_r;
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Master clock and sample tick
	logic [26:0] mclk_acc_r;   // Fractional divider toward the master rate
	logic        mclk_tick_r;  // One pulse per master clock
	logic [3:0]  div16_r;      // Master ticks within a sample
	logic        smp_tick_r;   // One pulse per sample

	// Fractional divider, so every rate follows MCLK_HZ
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mclk_acc_r  <= 27'h000_0000;
			mclk_tick_r <= 1'b0;
			div16_r     <= 4'h0;
			smp_tick_r  <= 1'b0;
		end else begin
			if (mclk_acc_r + 27'(MCLK_HZ) >= 27'(SYS_CLK_HZ)) begin
				mclk_acc_r  <= mclk_acc_r + 27'(MCLK_HZ) - 27'(SYS_CLK_HZ);
				mclk_tick_r <= 1'b1;
			end else begin
				mclk_acc_r  <= mclk_acc_r + 27'(MCLK_HZ);
				mclk_tick_r <= 1'b0;
			end
			smp_tick_r <= mclk_tick_r && div16_r == 4'(SAMPLE_DIV - 1);
			if (mclk_tick_r) begin
				div16_r <= div16_r + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sine phase and sample path
	tsg_mode_t   act_mode_r;   // Mode in force for the current sample
	logic [12:0] frac_acc_r;   // Ratio accumulator
	logic [9:0]  phase_r;      // Sine phase index
	logic signed [23:0] sample_r;  // Sample fed to the modulator
	logic [25:0] mod_acc_r;    // First-order modulator state

	// Ratio arithmetic: limit is (bottom+1) times 2^octave
	wire [12:0] frac_lim = 13'({4'h0, ratio_bot_r} + 13'h1) << octave_divider_bit;
	wire [12:0] frac_sum = frac_acc_r + 13'({1'b0, ratio_top_r} + 5'h1);
	wire        phase_step = frac_sum >= frac_lim;
	wire        sync_reset = (mode_fld == MODE_SINE) & phase_align_pin;
	// Attenuation split into whole 6 dB shifts and a residual mantissa
	wire        muted = wave_digital_atten_r[7:4] == MUTE_NIBBLE;
	wire [7:0]  shift6 = wave_digital_atten_r / ATTEN_PER_6DB;
	wire [7:0]  resid = wave_digital_atten_r - 8'(shift6 * ATTEN_PER_6DB);
	wire signed [40:0] scaled = sine_of(phase_r) * $signed({1'b0, mant_of(resid[3:0])});
	wire signed [23:0] sine_atten = 24'((scaled >>> 16) >>> shift6[4:0]);
	// Offset-binary modulator input: half density plus a quarter full scale
	wire [25:0] mod_in = {1'b0, ~sample_r[23], sample_r[22:0], 1'b0} + 26'h100_0000;
	wire [26:0] mod_sum = {1'b0, mod_acc_r} + {1'b0, mod_in};

	// Phase advance and restarts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frac_acc_r <= 13'h0000;
			phase_r    <= 10'h000;
		end else if (ratio_wr || sync_reset) begin
			frac_acc_r <= 13'h0000;
			phase_r    <= 10'h000;
		end else if (smp_tick_r) begin
			frac_acc_r <= phase_step ? frac_sum - frac_lim : frac_sum;
			phase_r    <= phase_r + {9'h000, phase_step};
		end
	end

	// Sample boundary: latch mode, choose source, step modulator
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_mode_r <= MODE_SINE;
			sample_r   <= 24'sh00_0000;
			mod_acc_r  <= 26'h000_0000;
			mod_bit    <= 1'b0;
		end else if (smp_tick_r) begin
			act_mode_r <= mode_fld;
			case (act_mode_r)
				MODE_SINE: sample_r <= muted ? 24'sh00_0000 : sine_atten;
				MODE_DC:   sample_r <= $signed(level_word_r);
				default:   sample_r <= 24'sh00_0000;
			endcase
			mod_acc_r <= mod_sum[25:0];
			if (pd_bit) begin
				mod_bit <= 1'b0;
			end else if (act_mode_r == MODE_DATA) begin
				mod_bit <= switch_or_bitstream_pin;
			end else begin
				mod_bit <= mod_sum[26];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog range, pulse converter and output enable
	wire [4:0] pulse_pick = phase_align_pin ? pulse_level_b_r : pulse_level_a_r;
	wire       pulse_on = act_mode_r == MODE_PULSE;

	// Outputs toward the analog side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			range_code <= 3'h0;
			pulse_neg  <= 1'b0;
			pulse_mag  <= 4'h0;
			pulse_sel  <= 1'b0;
			out_oe     <= 1'b0;
		end else begin
			range_code <= pulse_on ? 3'h0 : range_fld;
			pulse_sel  <= pulse_on;
			pulse_neg  <= pulse_on & pulse_pick[4];
			pulse_mag  <= pulse_on ? (pulse_pick[4] ? 4'(5'h10 - {1'b0, pulse_pick[3:0]}) :
				pulse_pick[3:0]) : 4'h0;
			out_oe     <= ~pd_bit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path
	wire [31:0] stat_word = {6'h00, phase_r, 13'h0000, muted, 2'(act_mode_r)};
	wire [31:0] rd_mux = (s_axi_araddr == OFS_CTRL)   ? ctrl_r :
		(s_axi_araddr == OFS_RATIO)  ? {16'h0000, ratio_bot_r, 4'h0, ratio_top_r} :
		(s_axi_araddr == OFS_ATTEN)  ? {24'h00_0000, wave_digital_atten_r} :
		(s_axi_araddr == OFS_LEVEL)  ? {8'h00, level_word_r} :
		(s_axi_araddr == OFS_PULSE)  ? {19'h0, pulse_level_b_r, 3'h0, pulse_level_a_r} :
		(s_axi_araddr == OFS_STATUS) ? stat_word : 32'h0000_0000;
	wire rd_ok = s_axi_araddr <= OFS_STATUS && s_axi_araddr[1:0] == 2'b00;

	// Read handshake and answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_ratio_write;
		ratio_wr ##1 1'b1;
	endsequence
	property p_ratio_restart;
		@(posedge aclk) disable iff (!aresetn) s_ratio_write |-> phase_r == 10'h000;
	endproperty
	a_ratio_restart: assert property (p_ratio_restart) else $error("ratio write kept phase");
	property p_sync_restart;
		@(posedge aclk) disable iff (!aresetn)
			(mode_fld == MODE_SINE && phase_align_pin) |=> phase_r == 10'h000;
	endproperty
	a_sync_restart: assert property (p_sync_restart) else $error("sync kept phase");
	property p_mode_boundary;
		@(posedge aclk) disable iff (!aresetn) !smp_tick_r |=> $stable(act_mode_r);
	endproperty
	a_mode_boundary: assert property (p_mode_boundary) else $error("mode moved mid sample");
	property p_tick_spacing;
		@(posedge aclk) disable iff (!aresetn) smp_tick_r |=> !smp_tick_r [*8];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("sample ticks too close");
	property p_mute;
		@(posedge aclk) disable iff (!aresetn)
			(smp_tick_r && act_mode_r == MODE_SINE && muted) |=> sample_r == 24'sh00_0000;
	endproperty
	a_mute: assert property (p_mute) else $error("muted sine not zero");
	property p_dc_level;
		@(posedge aclk) disable iff (!aresetn)
			(smp_tick_r && act_mode_r == MODE_DC) |=> sample_r == $signed($past(level_word_r));
	endproperty
	a_dc_level: assert property (p_dc_level) else $error("dc sample wrong");
	property p_bitstream;
		@(posedge aclk) disable iff (!aresetn) (smp_tick_r && act_mode_r == MODE_DATA && !pd_bit)
			|=> mod_bit == $past(switch_or_bitstream_pin);
	endproperty
	a_bitstream: assert property (p_bitstream) else $error("bitstream not passed");
	property p_pulse_pick;
		@(posedge aclk) disable iff (!aresetn) (pulse_on && phase_align_pin && pulse_level_b_r[4])
			|=> pulse_neg;
	endproperty
	a_pulse_pick: assert property (p_pulse_pick) else $error("pulse B not chosen");
	property p_pulse_range;
		@(posedge aclk) disable iff (!aresetn) pulse_on |=> range_code == 3'h0;
	endproperty
	a_pulse_range: assert property (p_pulse_range) else $error("range used in pulse");
	property p_power_down;
		@(posedge aclk) disable iff (!aresetn) pd_bit |=> !out_oe;
	endproperty
	a_power_down: assert property (p_power_down) else $error("outputs driven in power down");
endmodule // tsg_core

// ===== test/tsg_far_model.sv
// Far-side model: sync source and data-mode bitstream source
`timescale 1ns/1ps
module tsg_far_model #(
	parameter int SAMP = 32                   // Aclk cycles per bitstream bit
) (
	input  wire logic       aclk,
	input  wire logic       sync_req,
	input  wire logic [1:0] stream_sel,
	output logic            phase_align_pin,
	output logic            switch_or_bitstream_pin
);
	int tick_cnt = 0;                         // Bit period counter
	////////////////////////////////////////////////////////////////////////
	// Sync pin follows the request one edge later
	always @(posedge aclk) begin
		phase_align_pin <= sync_req;
	end
	// One bit per sample period: zeros, ones or alternating
	always @(posedge aclk) begin
		tick_cnt <= (tick_cnt == SAMP - 1) ? 0 : tick_cnt + 1;
		if (tick_cnt == 0) begin
			switch_or_bitstream_pin <= (stream_sel == 2'h2) ? !switch_or_bitstream_pin
				: stream_sel[0];
		end
	end
endmodule // tsg_far_model

// ===== test/tb_test_signal_mode_generator.sv
// Self-checking bench of the test-signal mode generator core
`timescale 1ns/1ps
module tb_test_signal_mode_generator;
	import tsg_pkg::*;
	localparam int MCLK = 25_000_000;         // Fast master clock, 2 aclk per tick
	localparam int SAMP = SYS_CLK_HZ / MCLK * SAMPLE_DIV;  // Aclk per sample
	logic        aclk = 1'b0;                 // System clock
	logic        aresetn = 1'b0;              // Reset, active low
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, rv;                   // Read data and a scratch word
	logic [1:0]  rs;                          // Scratch response
	logic        sync_req = 1'b0;             // Ask the far side for sync high
	logic [1:0]  stream_sel = 2'h0;           // Bitstream pattern
	logic        pa_pin, bs_pin, mod_bit, pulse_neg, pulse_sel, out_oe;
	logic [2:0]  range_code;
	logic [3:0]  pulse_mag;
	int          n_errors = 0, n_checks = 0, cnt;
	////////////////////////////////////////////////////////////////////////
	// Clock at 50 MHz
	always #10 aclk = ~aclk;
	// Design and far side
	tsg_core #(.MCLK_HZ(MCLK)) tsg_core_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .phase_align_pin(pa_pin),
		.switch_or_bitstream_pin(bs_pin), .mod_bit(mod_bit), .range_code(range_code),
		.pulse_neg(pulse_neg), .pulse_mag(pulse_mag), .pulse_sel(pulse_sel),
		.out_oe(out_oe));
	tsg_far_model #(.SAMP(SAMP)) tsg_far_model_inst (.aclk(aclk), .sync_req(sync_req),
		.stream_sel(stream_sel), .phase_align_pin(pa_pin), .switch_or_bitstream_pin(bs_pin));
	////////////////////////////////////////////////////////////////////////
	// Exact comparison
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Comparison within a tolerance
	task automatic near(input string nm, input int exp, input int got, input int tol);
		n_checks++;
		if (got < exp - tol || got > exp + tol) begin
			n_errors++;
			$display("wrong value %s expected %0d seen %0d", nm, exp, got);
		end
	endtask
	// Bus write, both channels released as each is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int   t;
		logic ad, wd;
		t = 0;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd) && t < 200) begin
			@(posedge aclk);
			t++;
			if (awready) ad = 1'b1;
			if (wready) wd = 1'b1;
			awvalid <= !ad;
			wvalid <= !wd;
		end
		while (!bvalid && t < 200) begin
			@(posedge aclk);
			t++;
		end
		bready <= 1'b0;
		check("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge aclk);
	endtask
	// Bus read
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		t = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
		end while (!arready && t < 200);
		arvalid <= 1'b0;
		while (!rvalid && t < 200) begin
			@(posedge aclk);
			t++;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// Read and compare data and answer
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		rd(a, rv, rs);
		check(nm, e, rv);
		check("rresp", {30'h0, er}, {30'h0, rs});
	endtask
	// Phase steps over 32 samples after a ratio write
	task automatic rate(input logic [31:0] c, input logic [31:0] r, input int e);
		wr(OFS_CTRL, c, 4'hF, RESP_OKAY);
		wr(OFS_RATIO, r, 4'hF, RESP_OKAY);
		repeat (32 * SAMP) @(posedge aclk);
		rd(OFS_STATUS, rv, rs);
		near("phase steps", e, int'(rv[STAT_PHASE_LSB +: 10]), 2);
	endtask
	// Ones counted over 64 samples
	task automatic ones();
		cnt = 0;
		repeat (64) begin
			repeat (SAMP) @(posedge aclk);
			cnt += int'(mod_bit);
		end
	endtask
	// Counts and verdict
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watchdog against a hang
	initial begin
		repeat (60000) @(posedge aclk);
		n_errors++;
		finish_test();
	end
	// Test sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		check("out_oe", 32'h1, {31'h0, out_oe});
		rchk("ctrl", OFS_CTRL, CTRL_RST, RESP_OKAY);
		rchk("ratio", OFS_RATIO, RATIO_RST, RESP_OKAY);
		rchk("atten", OFS_ATTEN, {24'h0, ATTEN_RST}, RESP_OKAY);
		rchk("level", OFS_LEVEL, {8'h0, LEVEL_RST}, RESP_OKAY);
		rchk("pulse", OFS_PULSE, 32'h0, RESP_OKAY);
		wr(8'h18, 32'h1, 4'hF, RESP_SLVERR);
		rchk("unmapped", 8'h18, 32'h0, RESP_SLVERR);
		wr(OFS_STATUS, 32'h1, 4'hF, RESP_SLVERR);
		wr(OFS_CTRL, 32'h0000_0040, 4'hF, RESP_OKAY);
		repeat (3) @(posedge aclk);
		check("out_oe", 32'h0, {31'h0, out_oe});
		wr(OFS_CTRL, 32'hFFFF_FFBF, 4'hF, RESP_OKAY);
		rchk("ctrl", OFS_CTRL, 32'h0000_003F, RESP_OKAY);
		check("out_oe", 32'h1, {31'h0, out_oe});
		$display("register test done");
		// Every mode with range code 5
		for (int m = 0; m < 4; m++) begin
			wr(OFS_CTRL, 32'(m) | (32'h5 << CTRL_RANGE_LSB), 4'hF, RESP_OKAY);
			repeat (3 * SAMP) @(posedge aclk);
			rd(OFS_STATUS, rv, rs);
			check("mode", 32'(m), {30'h0, rv[1:0]});
			check("pulse_sel", 32'(m == 3), {31'h0, pulse_sel});
			check("range", (m == 3) ? 32'h0 : 32'h5, {29'h0, range_code});
		end
		$display("mode test done");
		// Pulse levels chosen by sync
		wr(OFS_PULSE, 32'h0000_110F, 4'hF, RESP_OKAY);
		repeat (4) @(posedge aclk);
		check("pulse a", 32'h0F, {27'h0, pulse_neg, pulse_mag});
		sync_req <= 1'b1;
		repeat (4) @(posedge aclk);
		check("pulse b", 32'h1F, {27'h0, pulse_neg, pulse_mag});
		sync_req <= 1'b0;
		wr(OFS_PULSE, 32'h0000_0000, 4'h1, RESP_OKAY);
		repeat (4) @(posedge aclk);
		check("pulse zero", 32'h0, {27'h0, pulse_neg, pulse_mag});
		rchk("pulse", OFS_PULSE, 32'h0000_1100, RESP_OKAY);
		$display("pulse test done");
		// Mute by upper nibble, in sine mode so the muted sample path runs
		wr(OFS_CTRL, 32'h0000_0000, 4'hF, RESP_OKAY);
		wr(OFS_ATTEN, 32'h0000_00F3, 4'hF, RESP_OKAY);
		repeat (3 * SAMP) @(posedge aclk);
		rd(OFS_STATUS, rv, rs);
		check("mute", 32'h1, {31'h0, rv[STAT_MUTE_BIT]});
		wr(OFS_ATTEN, 32'h0000_00EF, 4'hF, RESP_OKAY);
		rd(OFS_STATUS, rv, rs);
		check("mute", 32'h0, {31'h0, rv[STAT_MUTE_BIT]});
		$display("mute test done");
		// Sine rate, octave, ratio and phase restarts
		rate(32'h0000_0000, 32'h0000_0000, 32);
		rate(32'h0000_0020, 32'h0000_0000, 16);
		rate(32'h0000_0000, 32'h0000_0301, 16);
		wr(OFS_RATIO, 32'h0000_FF00, 4'hF, RESP_OKAY);
		rd(OFS_STATUS, rv, rs);
		check("phase", 32'h0, {22'h0, rv[STAT_PHASE_LSB +: 10]});
		rate(32'h0000_0000, 32'h0000_0000, 32);
		sync_req <= 1'b1;
		repeat (4) @(posedge aclk);
		rd(OFS_STATUS, rv, rs);
		check("phase", 32'h0, {22'h0, rv[STAT_PHASE_LSB +: 10]});
		sync_req <= 1'b0;
		$display("sine test done");
		// Dc level density, positive and negative words
		wr(OFS_CTRL, 32'h0000_0001, 4'hF, RESP_OKAY);
		wr(OFS_LEVEL, 32'h003F_FFFF, 4'hF, RESP_OKAY);
		repeat (4 * SAMP) @(posedge aclk);
		ones();
		near("dc ones", 40, cnt, 3);
		wr(OFS_LEVEL, 32'h00C0_0000, 4'hF, RESP_OKAY);
		repeat (4 * SAMP) @(posedge aclk);
		ones();
		near("dc ones", 24, cnt, 3);
		$display("dc test done");
		// External bitstream passes straight through
		wr(OFS_CTRL, 32'h0000_0002, 4'hF, RESP_OKAY);
		for (int s = 0; s < 3; s++) begin
			stream_sel <= 2'(s);
			repeat (4 * SAMP) @(posedge aclk);
			ones();
			near("data ones", (s == 0) ? 0 : (s == 1) ? 64 : 32, cnt, 2);
		end
		$display("data test done");
		finish_test();
	end
endmodule // tb_test_signal_mode_generator
